// ==== common/adcpc_regs.vh ====
// Register offsets, field positions, encodings and timing counts for the converter control block
`ifndef ADCPC_REGS_VH
`define ADCPC_REGS_VH

// Register byte offsets on the 8-bit register port
`define ADCPC_OFS_CTRL        8'h00
`define ADCPC_OFS_CTRL2       8'h01
`define ADCPC_OFS_RES_HIGH    8'h02
`define ADCPC_OFS_RES_LOW     8'h03
`define ADCPC_OFS_CMP_HIGH    8'h04
`define ADCPC_OFS_CMP_LOW     8'h05
`define ADCPC_OFS_CONFIG      8'h06
`define ADCPC_OFS_PIN_LOW     8'h07
`define ADCPC_OFS_PIN_MID     8'h08
`define ADCPC_OFS_PIN_HIGH    8'h09

// Control register fields
`define ADCPC_CTRL_COMPLETE   7
`define ADCPC_CTRL_IRQ_EN     6
`define ADCPC_CTRL_CH_HI      4
`define ADCPC_CTRL_CH_LO      0
`define ADCPC_CH_DISABLED     5'h1f

// Second control register fields
`define ADCPC_CTRL2_ACTIVE    7
`define ADCPC_CTRL2_CMP_EN    5
`define ADCPC_CTRL2_CMP_GT    4

// Configuration register fields
`define ADCPC_CFG_DIV_HI      6
`define ADCPC_CFG_DIV_LO      5
`define ADCPC_CFG_MODE_HI     3
`define ADCPC_CFG_MODE_LO     2
`define ADCPC_CFG_CLK_HI      1
`define ADCPC_CFG_CLK_LO      0

// Encodings
`define ADCPC_CLK_BUS         2'h0
`define ADCPC_CLK_BUS_HALF    2'h1
`define ADCPC_CLK_ALT         2'h2
`define ADCPC_CLK_ASYNC       2'h3
`define ADCPC_MODE_8          2'h0
`define ADCPC_MODE_12         2'h1
`define ADCPC_MODE_10         2'h2

// Reset values
`define ADCPC_RST_CTRL        8'h1f
`define ADCPC_RST_ZERO        8'h00

// Timing: converter clock ticks spent sampling, bus cycles per internal oscillator tick
`define ADCPC_SAMPLE_TICKS    4'h4
`define ADCPC_ASYNC_DIV       3'h3
`endif

// ==== rtl/adcpc_top.v ====
// Converter control: register port, pin control, clock select/divide, SAR sequencing and results
//
// Decided for this implementation: the register addresses and strobed register access.
`timescale 1ns/10ps
`include "adcpc_regs.vh"

module adcpc_top (
    input  wire        sys_clk,
    input  wire        rstn,
    input  wire [7:0]  reg_addr,
    input  wire [7:0]  reg_wdata,
    input  wire        reg_wr,
    input  wire        reg_rd,
    output reg  [7:0]  reg_rdata,
    input  wire [23:0] port_pin_in,
    output reg  [23:0] port_read_value,
    output wire [23:0] pin_output_hiz,
    output wire [23:0] pin_input_disable,
    output wire [23:0] pin_pullup_disable,
    input  wire        alternate_clock,
    input  wire        stop_mode,
    input  wire        comparator_in,
    output reg  [11:0] dac_code_r,
    output reg  [4:0]  channel_select_r,
    output reg         converter_clock_r,
    output reg         async_clock_on_r,
    output reg         converter_powered_r,
    output reg         conv_irq_r
);

    localparam ST_IDLE   = 2'h0;
    localparam ST_SAMPLE = 2'h1;
    localparam ST_CONV   = 2'h2;
    localparam ST_STORE  = 2'h3;

    // Last divider count: ticks of the chosen source per converter clock tick, less one
    function [2:0] div_last;
        input [1:0] code;
        begin
            div_last = (3'h1 << code) - 3'h1;
        end
    endfunction

    // Round an approximation down by one bit, saturating at the mode's full scale
    function [9:0] round_drop;
        input [9:0] upper;
        input       half;
        input [9:0] full;
        reg   [10:0] sum;
        begin
            sum = {1'b0, upper} + {10'h000, half};
            round_drop = (sum > {1'b0, full}) ? full : sum[9:0];
        end
    endfunction

    reg  [7:0]  pin_low_r;
    reg  [7:0]  pin_mid_r;
    reg  [7:0]  pin_high_r;
    reg         complete_r;
    reg         irq_en_r;
    reg         cmp_en_r;
    reg         cmp_gt_r;
    reg  [1:0]  clk_sel_r;
    reg  [1:0]  div_sel_r;
    reg  [1:0]  mode_r;
    reg  [7:0]  cmp_high_r;
    reg  [7:0]  cmp_low_r;
    reg  [7:0]  res_high_r;
    reg  [7:0]  res_low_r;
    reg         res_hold_r;
    reg  [1:0]  state_r;
    reg  [3:0]  sample_cnt_r;
    reg  [11:0] bit_r;
    reg         half_r;
    reg         alt_prev_r;
    reg  [2:0]  osc_cnt_r;
    reg  [2:0]  div_cnt_r;

    wire [23:0] pin_dis = {pin_high_r, pin_mid_r, pin_low_r};
    wire        mode8   = (mode_r == `ADCPC_MODE_8);
    wire        mode10  = (mode_r == `ADCPC_MODE_10);

    wire wr_ctrl  = reg_wr && (reg_addr == `ADCPC_OFS_CTRL);
    wire ch_off   = (reg_wdata[`ADCPC_CTRL_CH_HI:`ADCPC_CTRL_CH_LO] == `ADCPC_CH_DISABLED);
    wire start    = wr_ctrl && !ch_off;
    // A change of mode, compare setup or clocking invalidates a running conversion
    wire cfg_wr   = reg_wr && ((reg_addr == `ADCPC_OFS_CTRL2) ||
                    (reg_addr == `ADCPC_OFS_CONFIG) || (reg_addr == `ADCPC_OFS_CMP_HIGH) ||
                    (reg_addr == `ADCPC_OFS_CMP_LOW));
    // Stop halts every source except the internal oscillator
    wire stop_abort = stop_mode && (clk_sel_r != `ADCPC_CLK_ASYNC);
    wire busy     = (state_r != ST_IDLE);
    wire abort    = busy && (wr_ctrl || cfg_wr || stop_abort);

    // Pin control outputs and port read gating
    assign pin_output_hiz     = pin_dis;
    assign pin_input_disable  = pin_dis;
    assign pin_pullup_disable = pin_dis;

    genvar gi;
    generate
        for (gi = 0; gi < 24; gi = gi + 1) begin : g_pin
            always @(posedge sys_clk or negedge rstn) begin
                if (!rstn) begin
                    port_read_value[gi] <= 1'b0;
                end else begin
                    port_read_value[gi] <= port_pin_in[gi] & ~pin_dis[gi];
                end
            end
        end
    endgenerate

    // Source tick: one of four clocks, each turned into a bus-cycle pulse
    reg src_tick;
    always @* begin
        case (clk_sel_r)
            `ADCPC_CLK_BUS:      src_tick = 1'b1;
            `ADCPC_CLK_BUS_HALF: src_tick = half_r;
            `ADCPC_CLK_ALT:      src_tick = alternate_clock & ~alt_prev_r;
            default:             src_tick = (osc_cnt_r == `ADCPC_ASYNC_DIV - 3'h1);
        endcase
    end

    wire converter_clock_tick = busy && src_tick && (div_cnt_r == div_last(div_sel_r));

    always @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            half_r            <= 1'b0;
            alt_prev_r        <= 1'b0;
            osc_cnt_r         <= 3'h0;
            div_cnt_r         <= 3'h0;
            converter_clock_r <= 1'b0;
            async_clock_on_r  <= 1'b0;
        end else begin
            half_r     <= ~half_r;
            alt_prev_r <= alternate_clock;
            // Oscillator only runs while selected and converting, saving power when idle
            if (busy && clk_sel_r == `ADCPC_CLK_ASYNC) begin
                osc_cnt_r <= (osc_cnt_r == `ADCPC_ASYNC_DIV - 3'h1) ? 3'h0 : osc_cnt_r + 3'h1;
            end else begin
                osc_cnt_r <= 3'h0;
            end
            async_clock_on_r <= busy && (clk_sel_r == `ADCPC_CLK_ASYNC);
            if (!busy) begin
                div_cnt_r <= 3'h0;
            end else if (src_tick) begin
                div_cnt_r <= (div_cnt_r == div_last(div_sel_r)) ? 3'h0 : div_cnt_r + 3'h1;
            end
            if (!busy) begin
                converter_clock_r <= 1'b0;
            end else if (converter_clock_tick) begin
                converter_clock_r <= ~converter_clock_r;
            end
        end
    end

    // Result shaping and compare
    reg  [11:0] shaped;
    reg  [11:0] cmp_val;
    reg  [11:0] width_mask;
    always @* begin
        if (mode8) begin
            shaped     = {2'b00, round_drop({2'b00, dac_code_r[11:4]}, dac_code_r[3],
                                            10'h0ff)};
            width_mask = 12'h0ff;
        end else if (mode10) begin
            shaped     = {2'b00, round_drop(dac_code_r[11:2], dac_code_r[1], 10'h3ff)};
            width_mask = 12'h3ff;
        end else begin
            shaped     = dac_code_r;
            width_mask = 12'hfff;
        end
        cmp_val = {cmp_high_r[3:0], cmp_low_r} & width_mask;
    end

    wire [11:0] diff     = shaped - cmp_val;
    wire        cmp_hit  = cmp_gt_r ? (shaped >= cmp_val) : (shaped < cmp_val);
    wire        keep     = !cmp_en_r || cmp_hit;
    wire [11:0] stored   = (cmp_en_r ? diff : shaped) & width_mask;
    wire        blocked  = res_hold_r && !mode8;
    wire        do_store = (state_r == ST_STORE) && keep && !blocked;
    wire        rd_high  = reg_rd && (reg_addr == `ADCPC_OFS_RES_HIGH);
    wire        rd_low   = reg_rd && (reg_addr == `ADCPC_OFS_RES_LOW);
    wire        last_bit = mode8 ? bit_r[3] : bit_r[0];

    // Approximation sequencer
    always @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            state_r             <= ST_IDLE;
            sample_cnt_r        <= 4'h0;
            bit_r               <= 12'h000;
            dac_code_r          <= 12'h000;
            converter_powered_r <= 1'b0;
        end else begin
            converter_powered_r <= busy || start;
            if (start) begin
                state_r      <= ST_SAMPLE;
                sample_cnt_r <= `ADCPC_SAMPLE_TICKS;
                dac_code_r   <= 12'h000;
            end else if (abort) begin
                state_r <= ST_IDLE;
            end else begin
                case (state_r)
                    ST_SAMPLE: begin
                        if (converter_clock_tick) begin
                            if (sample_cnt_r == 4'h1) begin
                                state_r    <= ST_CONV;
                                bit_r      <= 12'h800;
                                dac_code_r <= 12'h800;
                            end else begin
                                sample_cnt_r <= sample_cnt_r - 4'h1;
                            end
                        end
                    end
                    ST_CONV: begin
                        if (converter_clock_tick) begin
                            if (last_bit) begin
                                dac_code_r <= comparator_in ? dac_code_r : dac_code_r & ~bit_r;
                                state_r    <= ST_STORE;
                            end else begin
                                dac_code_r <= (comparator_in ? dac_code_r
                                              : dac_code_r & ~bit_r) | (bit_r >> 1);
                                bit_r      <= bit_r >> 1;
                            end
                        end
                    end
                    ST_STORE: begin
                        // A blocked transfer loses its result and converts again
                        if (blocked && keep) begin
                            state_r      <= ST_SAMPLE;
                            sample_cnt_r <= `ADCPC_SAMPLE_TICKS;
                            dac_code_r   <= 12'h000;
                        end else begin
                            state_r <= ST_IDLE;
                        end
                    end
                    default: state_r <= ST_IDLE;
                endcase
            end
        end
    end

    // Register file
    always @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            pin_low_r        <= `ADCPC_RST_ZERO;
            pin_mid_r        <= `ADCPC_RST_ZERO;
            pin_high_r       <= `ADCPC_RST_ZERO;
            channel_select_r <= `ADCPC_CH_DISABLED;
            irq_en_r         <= 1'b0;
            cmp_en_r         <= 1'b0;
            cmp_gt_r         <= 1'b0;
            clk_sel_r        <= `ADCPC_CLK_BUS;
            div_sel_r        <= 2'h0;
            mode_r           <= `ADCPC_MODE_8;
            cmp_high_r       <= `ADCPC_RST_ZERO;
            cmp_low_r        <= `ADCPC_RST_ZERO;
            res_high_r       <= `ADCPC_RST_ZERO;
            res_low_r        <= `ADCPC_RST_ZERO;
            res_hold_r       <= 1'b0;
            complete_r       <= 1'b0;
            conv_irq_r       <= 1'b0;
            reg_rdata        <= 8'h00;
        end else begin
            if (reg_wr) begin
                if (reg_addr == `ADCPC_OFS_CTRL) begin
                    irq_en_r         <= reg_wdata[`ADCPC_CTRL_IRQ_EN];
                    channel_select_r <= reg_wdata[`ADCPC_CTRL_CH_HI:`ADCPC_CTRL_CH_LO];
                end else if (reg_addr == `ADCPC_OFS_CTRL2) begin
                    cmp_en_r <= reg_wdata[`ADCPC_CTRL2_CMP_EN];
                    cmp_gt_r <= reg_wdata[`ADCPC_CTRL2_CMP_GT];
                end else if (reg_addr == `ADCPC_OFS_CMP_HIGH) begin
                    cmp_high_r <= reg_wdata;
                end else if (reg_addr == `ADCPC_OFS_CMP_LOW) begin
                    cmp_low_r <= reg_wdata;
                end else if (reg_addr == `ADCPC_OFS_CONFIG) begin
                    div_sel_r <= reg_wdata[`ADCPC_CFG_DIV_HI:`ADCPC_CFG_DIV_LO];
                    mode_r    <= reg_wdata[`ADCPC_CFG_MODE_HI:`ADCPC_CFG_MODE_LO];
                    clk_sel_r <= reg_wdata[`ADCPC_CFG_CLK_HI:`ADCPC_CFG_CLK_LO];
                end else if (reg_addr == `ADCPC_OFS_PIN_LOW) begin
                    pin_low_r <= reg_wdata;
                end else if (reg_addr == `ADCPC_OFS_PIN_MID) begin
                    pin_mid_r <= reg_wdata;
                end else if (reg_addr == `ADCPC_OFS_PIN_HIGH) begin
                    pin_high_r <= reg_wdata;
                end
            end

            // Reading high in 12/10-bit mode holds off new transfers until low is read
            if (rd_low) begin
                res_hold_r <= 1'b0;
            end else if (rd_high && !mode8) begin
                res_hold_r <= 1'b1;
            end

            if (do_store) begin
                res_high_r <= {4'h0, stored[11:8]};
                res_low_r  <= stored[7:0];
            end

            // Hardware set wins over the clear by a control write or a low result read
            if (do_store) begin
                complete_r <= 1'b1;
            end else if (wr_ctrl || rd_low) begin
                complete_r <= 1'b0;
            end
            conv_irq_r <= (do_store || (complete_r && !wr_ctrl && !rd_low))
                          && (wr_ctrl ? reg_wdata[`ADCPC_CTRL_IRQ_EN] : irq_en_r);

            if (reg_rd) begin
                if (reg_addr == `ADCPC_OFS_CTRL) begin
                    reg_rdata <= {complete_r, irq_en_r, 1'b0, channel_select_r};
                end else if (reg_addr == `ADCPC_OFS_CTRL2) begin
                    reg_rdata <= {busy, 1'b0, cmp_en_r, cmp_gt_r, 4'h0};
                end else if (reg_addr == `ADCPC_OFS_RES_HIGH) begin
                    reg_rdata <= res_high_r;
                end else if (reg_addr == `ADCPC_OFS_RES_LOW) begin
                    reg_rdata <= res_low_r;
                end else if (reg_addr == `ADCPC_OFS_CMP_HIGH) begin
                    reg_rdata <= cmp_high_r;
                end else if (reg_addr == `ADCPC_OFS_CMP_LOW) begin
                    reg_rdata <= cmp_low_r;
                end else if (reg_addr == `ADCPC_OFS_CONFIG) begin
                    reg_rdata <= {1'b0, div_sel_r, 1'b0, mode_r, clk_sel_r};
                end else if (reg_addr == `ADCPC_OFS_PIN_LOW) begin
                    reg_rdata <= pin_low_r;
                end else if (reg_addr == `ADCPC_OFS_PIN_MID) begin
                    reg_rdata <= pin_mid_r;
                end else if (reg_addr == `ADCPC_OFS_PIN_HIGH) begin
                    reg_rdata <= pin_high_r;
                end else begin
                    reg_rdata <= 8'h00;
                end
            end else begin
                reg_rdata <= 8'h00;
            end
        end
    end

endmodule

// ==== dv/adcpc_props.sv ====
// Concurrent checks on the converter control block ports
`timescale 1ns/10ps
`include "adcpc_regs.vh"
module adcpc_props (
    input wire        sys_clk,
    input wire        rstn,
    input wire [7:0]  reg_addr,
    input wire [7:0]  reg_wdata,
    input wire        reg_wr,
    input wire        reg_rd,
    input wire [7:0]  reg_rdata,
    input wire [23:0] port_pin_in,
    input wire [23:0] port_read_value,
    input wire [23:0] pin_output_hiz,
    input wire [23:0] pin_input_disable,
    input wire [23:0] pin_pullup_disable,
    input wire        stop_mode,
    input wire [4:0]  channel_select_r,
    input wire        converter_clock_r,
    input wire        async_clock_on_r,
    input wire        converter_powered_r,
    input wire        conv_irq_r
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rstn);
    pin_low_a: assert property (
        reg_wr && reg_addr == `ADCPC_OFS_PIN_LOW |=> pin_output_hiz[7:0] == $past(reg_wdata))
        else $error("low pin register write not applied");
    pin_mid_a: assert property (
        reg_rd && reg_addr == `ADCPC_OFS_PIN_MID |=> reg_rdata == $past(pin_output_hiz[15:8]))
        else $error("mid pin register read does not match pin controls");
    pin_high_a: assert property (
        reg_wr && reg_addr == `ADCPC_OFS_PIN_HIGH |=> pin_output_hiz[23:16] == $past(reg_wdata))
        else $error("high pin register write not applied");
    hiz_hold_a: assert property (
        !reg_wr |=> $stable(pin_output_hiz))
        else $error("pin high impedance changed without a write");
    port_mask_a: assert property (
        $past(rstn) |-> port_read_value == $past(port_pin_in & ~pin_input_disable))
        else $error("port read of a disabled pin not zero");
    pullup_off_a: assert property (
        pin_pullup_disable == pin_output_hiz && pin_input_disable == pin_output_hiz)
        else $error("pullup or input disable differs from pin control");
    chan_off_a: assert property (
        channel_select_r == `ADCPC_CH_DISABLED && $past(channel_select_r) == `ADCPC_CH_DISABLED
        |-> !converter_powered_r) else $error("converter powered with channel all ones");
    idle_quiet_a: assert property (
        !converter_powered_r && !$past(converter_powered_r) |-> !converter_clock_r)
        else $error("converter clock running while idle");
    stop_abort_a: assert property (
        stop_mode && converter_powered_r && !async_clock_on_r |-> ##[1:3] !converter_powered_r)
        else $error("conversion continued in stop without internal clock");
    cover property ($fell(converter_powered_r) && conv_irq_r);
    cover property (stop_mode && async_clock_on_r);
    cover property (reg_wr && reg_addr == `ADCPC_OFS_PIN_HIGH && reg_wdata == 8'hff);
endmodule
bind adcpc_top adcpc_props adcpc_props_inst (.sys_clk(sys_clk), .rstn(rstn),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .port_pin_in(port_pin_in), .port_read_value(port_read_value),
    .pin_output_hiz(pin_output_hiz), .pin_input_disable(pin_input_disable),
    .pin_pullup_disable(pin_pullup_disable), .stop_mode(stop_mode),
    .channel_select_r(channel_select_r), .converter_clock_r(converter_clock_r),
    .async_clock_on_r(async_clock_on_r), .converter_powered_r(converter_powered_r),
    .conv_irq_r(conv_irq_r));

// ==== dv/adcpc_pin_model.sv ====
// Port pin and analog input model on the far side of the block
`timescale 1ns/10ps
module adcpc_pin_model (
    input  wire        sys_clk,
    input  wire [11:0] analog_level,
    input  wire [23:0] pin_levels,
    input  wire [11:0] dac_code_r,
    input  wire [23:0] pin_input_disable,
    output wire        comparator_in,
    output wire [23:0] port_pin_in
);
    reg tog_r = 1'b0;
    always @(posedge sys_clk) tog_r <= ~tog_r;
    // A pin cut off from the port floats, so it shows a moving level, never a settled one
    assign port_pin_in = (pin_levels & ~pin_input_disable) | (pin_input_disable & {24{tog_r}});
    assign comparator_in = (analog_level >= dac_code_r);
endmodule

// ==== dv/adcpc_top_tb.sv ====
// Self-checking bench for the converter control block
`timescale 1ns/10ps
`include "adcpc_regs.vh"
module adcpc_top_tb;
    logic sys_clk, rstn, reg_wr, reg_rd, stop_mode, comparator_in, conv_irq_r;
    logic converter_clock_r, async_clock_on_r, converter_powered_r;
    logic [7:0] reg_addr, reg_wdata, reg_rdata, d;
    logic [23:0] port_pin_in, port_read_value, pin_output_hiz, pin_input_disable;
    logic [23:0] pin_pullup_disable, pins, v;
    logic [11:0] dac_code_r, ana;
    logic [4:0] channel_select_r;
    logic [1:0] alt_cnt;
    int err_total, cmp_count;
    adcpc_top adcpc_top_inst (.sys_clk(sys_clk), .rstn(rstn), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .port_pin_in(port_pin_in), .port_read_value(port_read_value),
        .pin_output_hiz(pin_output_hiz), .pin_input_disable(pin_input_disable),
        .pin_pullup_disable(pin_pullup_disable), .alternate_clock(alt_cnt[1]),
        .stop_mode(stop_mode), .comparator_in(comparator_in), .dac_code_r(dac_code_r),
        .channel_select_r(channel_select_r), .converter_clock_r(converter_clock_r),
        .async_clock_on_r(async_clock_on_r), .converter_powered_r(converter_powered_r),
        .conv_irq_r(conv_irq_r));
    adcpc_pin_model adcpc_pin_model_inst (.sys_clk(sys_clk), .analog_level(ana),
        .pin_levels(pins), .dac_code_r(dac_code_r), .pin_input_disable(pin_input_disable),
        .comparator_in(comparator_in), .port_pin_in(port_pin_in));
    initial begin
        sys_clk = 1'b0;
        forever #4 sys_clk = ~sys_clk;
    end
    // Alternate source: one rising edge every four bus cycles
    always @(posedge sys_clk) alt_cnt <= alt_cnt + 2'h1;
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            err_total++;
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic conclude;
        $display("Comparisons %0d, mismatches %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] dt);
        @(posedge sys_clk);
        reg_wr <= 1'b1; reg_addr <= a; reg_wdata <= dt;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] dt);
        @(posedge sys_clk);
        reg_rd <= 1'b1; reg_addr <= a;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        #1 dt = reg_rdata;
    endtask
    function automatic logic [11:0] exp_res(input logic [1:0] md, input logic [11:0] an);
        logic [12:0] s;
        if (md == `ADCPC_MODE_8) begin
            s = ((an >> 3) + 13'h1) >> 1;
            return (s > 13'h0ff) ? 12'h0ff : s[11:0];
        end
        if (md == `ADCPC_MODE_10) begin
            s = (an + 13'h2) >> 2;
            return (s > 13'h3ff) ? 12'h3ff : s[11:0];
        end
        return an;
    endfunction
    // Compare kind cm: 0 off, 1 below compare value, 2 at or above it
    task automatic conv(input logic [1:0] md, ck, dv, input logic ie, stp,
                        input logic [11:0] an, cmpv, input int cm);
        int n, t, nb, p;
        logic [11:0] r, mk;
        logic [7:0] h, l;
        logic dn;
        ana = an;
        r = exp_res(md, an);
        mk = (md == `ADCPC_MODE_8) ? 12'h0ff : (md == `ADCPC_MODE_10) ? 12'h3ff : 12'hfff;
        dn = (cm == 0) || (cm == 1 && r < cmpv) || (cm == 2 && r >= cmpv);
        if (cm != 0 && dn) r = (r - cmpv) & mk;
        if (stp && ck != `ADCPC_CLK_ASYNC) dn = 1'b0;
        wr(`ADCPC_OFS_CONFIG, {1'b0, dv, 1'b0, md, ck});
        wr(`ADCPC_OFS_CTRL, {1'b0, ie, 1'b0, 5'($urandom_range(23, 0))});
        n = 0;
        do begin
            @(posedge sys_clk);
            #1 n++;
            if (n == 2) chk("async clock", async_clock_on_r, ck == `ADCPC_CLK_ASYNC);
            if (stp && n == 6) stop_mode <= 1'b1;
        end while (converter_powered_r !== 1'b0 && n < 3000);
        if (n >= 3000) begin
            err_total++;
            conclude();
        end
        stop_mode <= 1'b0;
        nb = 4 + ((md == `ADCPC_MODE_8) ? 9 : 12);
        p = (ck == `ADCPC_CLK_ASYNC) ? 3 : (ck == `ADCPC_CLK_ALT) ? 4 : ck + 1;
        t = (1 << dv) * p;
        // First tick may come up to one source period early, depending on source phase
        if (dn && !stp) chk("duration", (n >= nb * t - p + 3 && n <= nb * t + 2), 1);
        chk("irq", conv_irq_r, ie & dn);
        rd(`ADCPC_OFS_CTRL, d);
        chk("complete", d[`ADCPC_CTRL_COMPLETE], dn);
        if (dn) begin
            rd(`ADCPC_OFS_RES_HIGH, h);
            rd(`ADCPC_OFS_RES_LOW, l);
            chk("result", {h, l}, {4'h0, r});
        end
    endtask
    initial begin
        reg_wr = 1'b0; reg_rd = 1'b0; reg_addr = 8'h00; reg_wdata = 8'h00;
        stop_mode = 1'b0; alt_cnt = 2'h0; ana = 12'h000; pins = 24'h000000;
        err_total = 0; cmp_count = 0; rstn = 1'b0;
        void'($urandom(32'h9d9b));
        repeat (16) @(posedge sys_clk);
        rstn <= 1'b1;
        for (int a = 7; a <= 9; a++) begin
            rd(8'(a), d);
            chk("pin reset", d, 8'h00);
        end
        rd(`ADCPC_OFS_CONFIG, d);
        chk("clock select reset", d[1:0], `ADCPC_CLK_BUS);
        rd(`ADCPC_OFS_CTRL, d);
        chk("ctrl reset", d, `ADCPC_RST_CTRL);
        for (int i = 0; i < 8; i++) begin
            v = (i == 0) ? 24'hffffff : (i == 1) ? 24'h000000 : 24'($urandom);
            wr(`ADCPC_OFS_PIN_LOW, v[7:0]);
            wr(`ADCPC_OFS_PIN_MID, v[15:8]);
            wr(`ADCPC_OFS_PIN_HIGH, v[23:16]);
            rd(`ADCPC_OFS_PIN_LOW, d);
            chk("pin low", d, v[7:0]);
            rd(`ADCPC_OFS_PIN_MID, d);
            chk("pin mid", d, v[15:8]);
            rd(`ADCPC_OFS_PIN_HIGH, d);
            chk("pin high", d, v[23:16]);
            chk("hiz", pin_output_hiz, v);
            chk("pullup", pin_pullup_disable, v);
            pins <= 24'($urandom);
            repeat (3) @(posedge sys_clk);
            #1 chk("port read", port_read_value, pins & ~v);
        end
        rd(8'h0a, d);
        chk("unmapped", d, 8'h00);
        conv(`ADCPC_MODE_10, `ADCPC_CLK_BUS, 2'h0, 1'b1, 1'b0, 12'hfff, 12'h0, 0);
        for (int i = 0; i < 8; i++)
            conv(2'(i % 3), 2'(i), 2'(i * 3 / 2), 1'(i % 2), 1'b0, 12'($urandom), 12'h0, 0);
        conv(`ADCPC_MODE_8, `ADCPC_CLK_BUS, 2'h0, 1'b1, 1'b0, 12'hffc, 12'h0, 0);
        wr(`ADCPC_OFS_CTRL, 8'h5f);
        repeat (3) @(posedge sys_clk);
        #1 chk("disabled", converter_powered_r, 1'b0);
        chk("channel", channel_select_r, `ADCPC_CH_DISABLED);
        wr(`ADCPC_OFS_CMP_HIGH, 8'h0f);
        wr(`ADCPC_OFS_CMP_LOW, 8'hff);
        wr(`ADCPC_OFS_CTRL2, 8'h20);
        conv(`ADCPC_MODE_12, `ADCPC_CLK_BUS, 2'h0, 1'b1, 1'b0, 12'h5a3, 12'hfff, 1);
        wr(`ADCPC_OFS_CTRL2, 8'h30);
        conv(`ADCPC_MODE_12, `ADCPC_CLK_BUS, 2'h0, 1'b1, 1'b0, 12'h5a3, 12'hfff, 2);
        wr(`ADCPC_OFS_CTRL2, 8'h00);
        conv(`ADCPC_MODE_12, `ADCPC_CLK_BUS, 2'h2, 1'b1, 1'b1, 12'h123, 12'h0, 0);
        conv(`ADCPC_MODE_12, `ADCPC_CLK_ASYNC, 2'h0, 1'b1, 1'b1, 12'h9c4, 12'h0, 0);
        conclude();
    end
endmodule
